// >>> core/sfcid_core.sv
/*
 * sfcid_core: control and identification command handling of a serial
 * flash: reset pair, write-enable latch, factory mode, id reads and
 * deep power-down release.
 * assumes: sclk and csN come from the host; the array logic on ref_clk
 * supplies busy, power-down entry and completion pulses.
 */
// Functional notes
// - no-op, reset-arm, reset-execute are lone opcodes in either command mode
// - reset-execute acts only when reset-arm was the previous command
// - write-enable sets the latch; frame is select low, opcode, select high
// - opcode arrives as 8 clocks on one line or 2 clocks on four
// - write-disable clears the write-enable latch
// - latch clears on reset, soft reset and write-type completions
// - suspend is refused while factory mode is set
// - factory mode clears on reset, soft reset, program or erase completion
// - ident read shifts maker, type, density bytes until select rises
// - ident read is not decoded while the array is busy
// - ident read works only in single-line mode
// - release waits the first delay when leaving deep power-down
// - release opcode and hardware reset both leave deep power-down
// - signature byte repeats while clocking continues
// - signature read from deep power-down waits the second delay
// - release and signature do nothing while the array is busy
// - maker/device read: opcode, two dummy bytes, address, msb first
// - address bit selects first code; codes alternate until select rises
// - maker/device read works only in single-line mode
`timescale 1ns/1ps
`default_nettype none

module sfcid_core
    import sfcid_pkg::*;
#(
    parameter logic [7:0] MAKER_CODE = 8'h5a  // arbitrary value
) (
    // reference clock and reset
    input  wire logic       ref_clk,
    input  wire logic       rst,
    // serial link
    input  wire logic       sclk,
    input  wire logic       csN,
    input  wire logic [3:0] dqIn,
    output var  logic [3:0] dqOut,
    output var  logic [3:0] dqOe,
    // array side
    input  wire logic       quadMode,
    input  wire logic       arrayBusy,
    input  wire logic       powerDownRequest,
    input  wire logic       progEraseDone,
    input  wire logic       writeOpDone,
    // state outputs
    output var  logic       writeEnableLatch,
    output var  logic       factoryMode,
    output var  logic       suspendAllowed,
    output var  logic       softReset,
    output var  logic       deepPowerDown,
    output var  logic       standby
);

    // ****************************************
    // link domain: frame reception
    // ****************************************
    logic       frameRst;
    logic       qpiSync1, qpiLink;
    logic       busySync1, busyLink;
    logic       dpdSync1, dpdLink;
    logic [5:0] rxBits;
    logic [5:0] next_rxBits;
    logic [7:0] inShift;
    logic [7:0] next_inShift;
    logic [7:0] opcodeHeld;
    logic       frameTgl;
    logic       extraClocks;
    logic       remsDevFirst;
    logic       opcodeDone;
    logic       addrDone;

    // frame logic is cleared whenever select is high
    assign frameRst = rst | csN;

    // one bit per clock on one line, a nibble on four
    assign next_inShift = qpiLink ? {inShift[3:0], dqIn} : {inShift[6:0], dqIn[0]};
    assign next_rxBits  = (rxBits >= RX_SATURATE) ? rxBits :
                          (rxBits + (qpiLink ? 6'd4 : 6'd1));
    assign opcodeDone   = (next_rxBits == OPCODE_BITS) && (rxBits != OPCODE_BITS);
    assign addrDone     = (next_rxBits == MAKER_DEVICE_CODE_READ_CMD_ADDR_END) && (rxBits != MAKER_DEVICE_CODE_READ_CMD_ADDR_END);

    // mode, busy and sleep levels synchronised to the link clock
    always_ff @(posedge sclk or posedge rst) begin
        if (rst) begin
            qpiSync1  <= 1'b0;
            qpiLink   <= 1'b0;
            busySync1 <= 1'b0;
            busyLink  <= 1'b0;
            dpdSync1  <= 1'b0;
            dpdLink   <= 1'b0;
        end else begin
            qpiSync1  <= quadMode;
            qpiLink   <= qpiSync1;
            busySync1 <= arrayBusy;
            busyLink  <= busySync1;
            dpdSync1  <= deepPowerDown;
            dpdLink   <= dpdSync1;
        end
    end

    // bit count restarts with every frame
    always_ff @(posedge sclk or posedge frameRst) begin
        if (frameRst) begin
            rxBits <= 6'd0;
        end else begin
            rxBits <= next_rxBits;
        end
    end

    // opcode, address bit and frame toggle survive select rising
    always_ff @(posedge sclk or posedge rst) begin
        if (rst) begin
            inShift      <= 8'h00;
            opcodeHeld   <= 8'h00;
            frameTgl     <= 1'b0;
            extraClocks  <= 1'b0;
            remsDevFirst <= 1'b0;
        end else begin
            inShift <= next_inShift;
            if (opcodeDone) begin
                opcodeHeld  <= next_inShift;
                frameTgl    <= ~frameTgl;  // event to the core
                extraClocks <= 1'b0;
            end else if (rxBits >= OPCODE_BITS) begin
                extraClocks <= 1'b1;       // clocks past the opcode
            end
            if (addrDone) begin
                remsDevFirst <= next_inShift[0];
            end
        end
    end

    // ****************************************
    // link domain: id data out
    // ****************************************
    logic        isIdent, isSig, isRems;
    logic        dataPhase;
    logic [5:0]  dataStart;
    logic [4:0]  wordLen;
    logic [4:0]  outIdx;
    logic [4:0]  stepIdx;
    logic [4:0]  next_outIdx;
    logic [23:0] outWord;
    logic [23:0] shiftedWord;

    // which read is running, and where its data begins
    assign isIdent = (opcodeHeld == READ_THREE_BYTE_IDENT_CMD) && !qpiLink
                     && !busyLink && !dpdLink;
    assign isSig   = (opcodeHeld == LEGACY_SIGNATURE_READ_CMD) && !busyLink;
    assign isRems  = (opcodeHeld == MAKER_DEVICE_CODE_READ_CMD) && !qpiLink
                     && !busyLink && !dpdLink;
    assign dataStart = isIdent ? OPCODE_BITS : (isSig ? SIG_DATA_START : MAKER_DEVICE_CODE_READ_CMD_ADDR_END);
    assign wordLen   = isIdent ? IDENT_LEN : (isSig ? SIG_LEN : MAKER_DEVICE_CODE_READ_CMD_LEN);
    assign dataPhase = (isIdent || isSig || isRems) && (rxBits >= dataStart);

    // data word, most significant bit aligned to bit 23
    assign outWord = isIdent ? {MAKER_CODE, MEMORY_TYPE_CODE, DENSITY_CODE} :
                     isSig ? {SIGNATURE_CODE, 16'h0000} :
                     remsDevFirst ? {DEVICE_CODE, MAKER_CODE, 8'h00} :
                     {MAKER_CODE, DEVICE_CODE, 8'h00};
    assign shiftedWord = outWord << outIdx;

    // index wraps so the word repeats until select rises
    assign stepIdx     = outIdx + (qpiLink ? 5'd4 : 5'd1);
    assign next_outIdx = (stepIdx >= wordLen) ? (stepIdx - wordLen) : stepIdx;

    // drive on the falling clock, msb first
    always_ff @(negedge sclk or posedge frameRst) begin
        if (frameRst) begin
            dqOut  <= 4'h0;
            dqOe   <= 4'h0;
            outIdx <= 5'd0;
        end else if (dataPhase) begin
            dqOut  <= qpiLink ? shiftedWord[23:20] : {2'b00, shiftedWord[23], 1'b0};
            dqOe   <= qpiLink ? 4'hf : 4'h2;
            outIdx <= next_outIdx;
        end else begin
            dqOut  <= 4'h0;
            dqOe   <= 4'h0;
        end
    end

    // ****************************************
    // core domain: frame end detection
    // ****************************************
    logic       csSync1, csSync2, csPrev;
    logic       tglSync1, tglSync2, tglSeen;
    logic       csRise;
    logic       newFrame;

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            csSync1  <= 1'b1;
            csSync2  <= 1'b1;
            csPrev   <= 1'b1;
            tglSync1 <= 1'b0;
            tglSync2 <= 1'b0;
            tglSeen  <= 1'b0;
        end else begin
            csSync1  <= csN;
            csSync2  <= csSync1;
            csPrev   <= csSync2;
            tglSync1 <= frameTgl;
            tglSync2 <= tglSync1;
            if (csRise) begin
                tglSeen <= tglSync2;
            end
        end
    end

    // a frame counts only if a whole opcode came in
    assign csRise   = csSync2 & ~csPrev;
    assign newFrame = csRise && (tglSync2 != tglSeen);

    // ****************************************
    // core domain: command decode
    // ****************************************
    sfcid_pwr_t pwrState, next_pwrState;
    logic [15:0] relCnt, next_relCnt;
    logic       armed, next_armed;
    logic       awake;
    logic       anyCmd, cmdArm, cmdExec, cmdWren, cmdWrdi, cmdFmen;
    logic       wakeCmd;
    logic       next_wel, next_factory;

    // opcodes act at select rise, only when awake; release acts only in deep power-down
    assign awake   = (pwrState == PWR_STANDBY);
    assign anyCmd  = newFrame && awake;
    assign cmdArm  = anyCmd && (opcodeHeld == RESET_ARM_CMD);
    assign cmdExec = anyCmd && (opcodeHeld == RESET_EXECUTE_CMD) && armed;
    assign cmdWren = anyCmd && (opcodeHeld == WRITE_ENABLE_CMD);
    assign cmdWrdi = anyCmd && (opcodeHeld == WRITE_DISABLE_CMD);
    assign cmdFmen = anyCmd && (opcodeHeld == FACTORY_MODE_ENABLE_CMD);
    assign wakeCmd = newFrame && (pwrState == PWR_DEEP) && !arrayBusy
                     && (opcodeHeld == POWER_DOWN_RELEASE_CMD);

    // any other full command disarms the reset pair
    assign next_armed = cmdArm ? 1'b1 : (anyCmd ? 1'b0 : armed);

    // set wins over every clear
    assign next_wel = cmdWren ? 1'b1 :
                      (cmdWrdi || cmdExec || progEraseDone || writeOpDone) ? 1'b0 :
                      writeEnableLatch;
    assign next_factory = cmdFmen ? 1'b1 :
                          (cmdExec || progEraseDone) ? 1'b0 : factoryMode;

    // power state: sleep, timed release, standby
    always_comb begin
        next_pwrState = pwrState;
        next_relCnt   = relCnt;
        unique case (pwrState)
            PWR_STANDBY: begin
                if (powerDownRequest) begin
                    next_pwrState = PWR_DEEP;
                end
            end
            PWR_DEEP: begin
                if (wakeCmd) begin
                    next_pwrState = PWR_RELEASE;
                    next_relCnt   = extraClocks ? 16'(REL2_CYC) : 16'(REL1_CYC);
                end
            end
            PWR_RELEASE: begin
                if (relCnt <= 16'd1) begin
                    next_pwrState = PWR_STANDBY;
                end else begin
                    next_relCnt = relCnt - 16'd1;
                end
            end
        endcase
    end

    // state registers; hardware reset also ends deep power-down
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            pwrState         <= PWR_STANDBY;
            relCnt           <= 16'd0;
            armed            <= 1'b0;
            writeEnableLatch <= 1'b0;
            factoryMode      <= 1'b0;
            suspendAllowed   <= 1'b1;
            softReset        <= 1'b0;
            deepPowerDown    <= 1'b0;
            standby          <= 1'b1;
        end else begin
            pwrState         <= next_pwrState;
            relCnt           <= next_relCnt;
            armed            <= next_armed;
            writeEnableLatch <= next_wel;
            factoryMode      <= next_factory;
            suspendAllowed   <= ~next_factory;
            softReset        <= cmdExec;
            deepPowerDown    <= (next_pwrState == PWR_DEEP);
            standby          <= (next_pwrState == PWR_STANDBY);
        end
    end

    // ****************************************
    // checks
    // ****************************************
    localparam int CHK_REL1 = REL1_CYC - 1;
    localparam int CHK_REL2 = REL2_CYC - 1;

    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (rst);

    sequence s_wait_one;
        !standby throughout ##CHK_REL1 1'b1;
    endsequence

    sequence s_wait_two;
        !standby throughout ##CHK_REL2 1'b1;
    endsequence

    chk_reset_fires: assert property (
        anyCmd && (opcodeHeld == RESET_EXECUTE_CMD) && armed |=> softReset && !writeEnableLatch)
        else $error("armed reset-execute did not reset");

    chk_reset_pair: assert property (
        anyCmd && (opcodeHeld == RESET_EXECUTE_CMD) && !armed |=> !softReset)
        else $error("reset-execute acted without arm");

    chk_wel_set: assert property (
        cmdWren |=> writeEnableLatch)
        else $error("write-enable did not set latch");

    chk_wel_disable: assert property (
        cmdWrdi |=> !writeEnableLatch)
        else $error("write-disable did not clear latch");

    chk_wel_done_clear: assert property (
        (progEraseDone || writeOpDone) && !cmdWren |=> !writeEnableLatch)
        else $error("completion left latch set");

    chk_factory_clear: assert property (
        (progEraseDone || cmdExec) && !cmdFmen |=> !factoryMode)
        else $error("factory mode survived completion");

    chk_no_suspend: assert property (
        factoryMode |-> !suspendAllowed)
        else $error("suspend allowed in factory mode");

    chk_release_one: assert property (
        wakeCmd && !extraClocks |=> s_wait_one ##1 standby)
        else $error("release delay one wrong");

    chk_release_two: assert property (
        wakeCmd && extraClocks |=> s_wait_two ##1 standby)
        else $error("release delay two wrong");

    chk_busy_no_wake: assert property (
        (pwrState == PWR_DEEP) && arrayBusy && !powerDownRequest |=> deepPowerDown)
        else $error("left deep power-down while busy");

    chk_partial_frame: assert property (
        csRise && !newFrame && !progEraseDone && !writeOpDone
        |=> $stable(writeEnableLatch) && $stable(factoryMode) && !softReset)
        else $error("partial frame changed state");

endmodule // sfcid_core

`default_nettype wire

// >>> core/sfcid_pkg.sv
/*
 * sfcid_pkg: opcodes, identification codes, frame bit positions and
 * release timing for the flash control and identification command block.
 * assumes a 20 MHz reference clock and an opcode-first serial frame.
 */
package sfcid_pkg;

    // ****************************************
    // command opcodes
    // ****************************************
    localparam logic [7:0] NO_OPERATION_CMD        = 8'h00;
    localparam logic [7:0] RESET_ARM_CMD           = 8'h66;
    localparam logic [7:0] RESET_EXECUTE_CMD       = 8'h99;
    localparam logic [7:0] WRITE_ENABLE_CMD        = 8'h06;
    localparam logic [7:0] WRITE_DISABLE_CMD       = 8'h04;
    localparam logic [7:0] FACTORY_MODE_ENABLE_CMD = 8'h41;
    localparam logic [7:0] READ_THREE_BYTE_IDENT_CMD  = 8'h9f;
    localparam logic [7:0] LEGACY_SIGNATURE_READ_CMD  = 8'hab;
    localparam logic [7:0] POWER_DOWN_RELEASE_CMD     = 8'hab;
    localparam logic [7:0] MAKER_DEVICE_CODE_READ_CMD = 8'h90;

    // ****************************************
    // identification bytes (maker code is a module parameter)
    // ****************************************
    localparam logic [7:0] MEMORY_TYPE_CODE  = 8'h20;
    localparam logic [7:0] DENSITY_CODE      = 8'h19;
    localparam logic [7:0] DEVICE_CODE       = 8'h18;
    localparam logic [7:0] SIGNATURE_CODE    = 8'h18;

    // ****************************************
    // frame bit positions and data word lengths
    // ****************************************
    localparam logic [5:0] OPCODE_BITS    = 6'd8;
    localparam logic [5:0] SIG_DATA_START = 6'd24;
    localparam logic [5:0] MAKER_DEVICE_CODE_READ_CMD_ADDR_END  = 6'd32;
    localparam logic [5:0] RX_SATURATE    = 6'd56;
    localparam logic [4:0] IDENT_LEN      = 5'd24;
    localparam logic [4:0] SIG_LEN        = 5'd8;
    localparam logic [4:0] MAKER_DEVICE_CODE_READ_CMD_LEN       = 5'd16;

    // ****************************************
    // release timing
    // ****************************************
    localparam int REF_CLK_MHZ          = 20;
    localparam int RELEASE_DELAY_ONE_NS = 10000;
    localparam int RELEASE_DELAY_TWO_NS = 10000;
    localparam int REL1_RAW = RELEASE_DELAY_ONE_NS * REF_CLK_MHZ / 1000;
    localparam int REL2_RAW = RELEASE_DELAY_TWO_NS * REF_CLK_MHZ / 1000;
    localparam int REL1_CYC = (REL1_RAW < 1) ? 1 : REL1_RAW;
    localparam int REL2_CYC = (REL2_RAW < 1) ? 1 : REL2_RAW;

    // ****************************************
    // power state
    // ****************************************
    typedef enum logic [1:0] {
        PWR_STANDBY,
        PWR_DEEP,
        PWR_RELEASE
    } sfcid_pwr_t;

endpackage

// >>> dv/sfcid_host_model.sv
/*
 * sfcid_host_model: behavioural host controller that frames commands on the
 * serial link (mode 0, 125 ns link clock, idle low outside frames).
 * assumes the core drives dqOut on falling sclk and clears dqOe at csN high.
 */
`timescale 1ns/1ps
`default_nettype none

module sfcid_host_model (
    // link outputs
    output var  logic       sclk,
    output var  logic       csN,
    output var  logic [3:0] dqIn,
    // device answer
    input  wire logic [3:0] dqOut,
    input  wire logic [3:0] dqOe
);
    initial begin
        sclk = 1'b0;
        csN  = 1'b1;
        dqIn = 4'h0;
    end

    // one frame of n rising edges, tx msb first; tx is sent as given, whatever opcode it holds
    task automatic frame(input logic [63:0] tx, input int n, input bit quad,
                         output logic [63:0] rx, output logic oeAny);
        rx    = '0;
        oeAny = 1'b0;
        #7;
        csN = 1'b0;
        for (int i = 0; i < n; i++) begin
            #31;
            // upper lines carry noise in single-line mode
            dqIn = quad ? tx[63:60] : {3'($urandom), tx[63]};
            tx   = quad ? tx << 4 : tx << 1;
            #31.5;
            sclk  = 1'b1;
            rx    = {rx[62:0], dqOut[1]};
            oeAny = oeAny | (|dqOe);
            #62.5;
            sclk = 1'b0;
        end
        #31;
        csN  = 1'b1; // frame ends at select high
        dqIn = ~dqIn; // released lines do not keep the last value
        #250; // select high long enough for the core to see it
    endtask
endmodule // sfcid_host_model

`default_nettype wire

// >>> dv/tb_top.sv
/*
 * tb_top: self-checking bench for sfcid_core; expected results queue up
 * and a monitor compares them with what the outputs show.
 * assumes sfcid_pkg and the host model are compiled first.
 */
`timescale 1ns/1ps
`default_nettype none

module tb_top;
    import sfcid_pkg::*;
    localparam logic [7:0] MAKER = 8'h3c; // arbitrary value
    logic ref_clk = 1'b0, rst = 1'b1, quadMode = 1'b0, arrayBusy = 1'b0;
    logic powerDownRequest = 1'b0, progEraseDone = 1'b0, writeOpDone = 1'b0;
    wire  logic sclk, csN, writeEnableLatch, factoryMode, suspendAllowed, softReset, deepPowerDown, standby;
    wire  logic [3:0] dqIn, dqOut, dqOe;
    wire  logic [4:0] stat = {writeEnableLatch, factoryMode, suspendAllowed, deepPowerDown, standby};
    logic [63:0] expQ[$], obsVal, rx;
    string nameQ[$];
    logic oe;
    event resultEv;
    int errTotal = 0, compares = 0, resetPulses = 0;

    sfcid_core #(.MAKER_CODE(MAKER)) i_dut (.ref_clk(ref_clk), .rst(rst), .sclk(sclk), .csN(csN),
        .dqIn(dqIn), .dqOut(dqOut), .dqOe(dqOe), .quadMode(quadMode), .arrayBusy(arrayBusy),
        .powerDownRequest(powerDownRequest), .progEraseDone(progEraseDone), .writeOpDone(writeOpDone),
        .writeEnableLatch(writeEnableLatch), .factoryMode(factoryMode), .suspendAllowed(suspendAllowed),
        .softReset(softReset), .deepPowerDown(deepPowerDown), .standby(standby));
    sfcid_host_model i_host (.sclk(sclk), .csN(csN), .dqIn(dqIn), .dqOut(dqOut), .dqOe(dqOe));

    always #25 ref_clk = ~ref_clk;

    // counts soft reset pulses, sampled away from the launching edge
    always @(negedge ref_clk) if (softReset === 1'b1) resetPulses++;

    // ****************************************
    // checking and closing
    // ****************************************
    task automatic check(string name, logic [63:0] seen, logic [63:0] exp);
        compares++;
        if (seen !== exp) begin
            errTotal++;
            $display("mismatch %s expected %h seen %h", name, exp, seen);
        end
    endtask
    task automatic wrap_up();
        if (errTotal == 0 && compares > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask
    // monitor takes the oldest note whenever a result shows
    always @(resultEv) check(nameQ.pop_front(), obsVal, expQ.pop_front());
    task automatic note(string n, logic [63:0] e);
        nameQ.push_back(n);
        expQ.push_back(e);
    endtask
    task automatic seen(logic [63:0] v);
        obsVal = v;
        -> resultEv;
        #1;
    endtask

    // ****************************************
    // stimulus helpers
    // ****************************************
    task automatic cyc(int n);
        repeat (n) @(posedge ref_clk);
    endtask
    task automatic chk(string n, logic [4:0] e);
        note(n, 64'(e));
        #1;
        seen(64'(stat));
    endtask
    task automatic cmd(logic [7:0] op, bit q, logic [4:0] e);
        i_host.frame({op, 56'h0}, q ? 2 : 8, q, rx, oe);
        cyc(2);
        chk($sformatf("status after %h", op), e);
    endtask
    task automatic rd(logic [63:0] tx, int n, bit q, logic [31:0] m, logic [32:0] e);
        i_host.frame(tx, n, q, rx, oe);
        note($sformatf("read of %h", tx[63:56]), 64'(e));
        seen(q ? 64'(oe) : 64'({oe, rx[31:0] & m}));
    endtask
    task automatic pulse(int k);
        @(posedge ref_clk) {powerDownRequest, writeOpDone, progEraseDone} <= 3'(1 << k);
        @(posedge ref_clk) {powerDownRequest, writeOpDone, progEraseDone} <= 3'h0;
        cyc(3);
    endtask
    task automatic set_mode(bit q);
        @(posedge ref_clk) quadMode <= q;
        cmd(NO_OPERATION_CMD, q, stat); // no-op frame also clocks the mode across
    endtask

    // ****************************************
    // main sequence
    // ****************************************
    initial begin
        void'($urandom(32'he108));
        cyc(4);
        rst <= 1'b0;
        cyc(3);
        chk("status after reset", 5'b00101);
        for (int q = 0; q < 2; q++) begin
            set_mode(q[0]);
            cmd(WRITE_ENABLE_CMD, q[0], 5'b10101);
            cmd(WRITE_DISABLE_CMD, q[0], 5'b00101);
            cmd(WRITE_ENABLE_CMD, q[0], 5'b10101);
            cmd(FACTORY_MODE_ENABLE_CMD, q[0], 5'b11001);
            pulse(0);
            chk("status after completion", 5'b00101);
            cmd(WRITE_ENABLE_CMD, q[0], 5'b10101);
            cmd(RESET_ARM_CMD, q[0], 5'b10101);
            cmd(NO_OPERATION_CMD, q[0], 5'b10101);
            cmd(RESET_EXECUTE_CMD, q[0], 5'b10101);
            cmd(RESET_ARM_CMD, q[0], 5'b10101);
            i_host.frame({WRITE_DISABLE_CMD, 56'h0}, q ? 1 : 4, q[0], rx, oe);
            chk("status after partial", 5'b10101);
            cmd(RESET_EXECUTE_CMD, q[0], 5'b00101);
            cmd(WRITE_ENABLE_CMD, q[0], 5'b10101);
            pulse(1);
            chk("status after write done", 5'b00101);
            rd({READ_THREE_BYTE_IDENT_CMD, 56'h0}, 40, q[0], 32'hffffffff,
               q ? 33'h0 : {1'b1, MAKER, MEMORY_TYPE_CODE, DENSITY_CODE, MAKER});
            for (int a = 0; a < 2; a++)
                rd({MAKER_DEVICE_CODE_READ_CMD, 16'h0, 8'(a), 32'h0}, 64, q[0], 32'hffffffff, q ? 33'h0 :
                   a ? {1'b1, {2{DEVICE_CODE, MAKER}}} : {1'b1, {2{MAKER, DEVICE_CODE}}});
        end
        set_mode(1'b0);
        @(posedge ref_clk) arrayBusy <= 1'b1;
        rd({READ_THREE_BYTE_IDENT_CMD, 56'h0}, 40, 1'b0, 32'h0, 33'h0);
        pulse(2);
        chk("status after sleep", 5'b00110);
        cmd(POWER_DOWN_RELEASE_CMD, 1'b0, 5'b00110);
        @(posedge ref_clk) arrayBusy <= 1'b0;
        cmd(WRITE_ENABLE_CMD, 1'b0, 5'b00110);
        cmd(POWER_DOWN_RELEASE_CMD, 1'b0, 5'b00100);
        cyc(REL1_CYC - 20);
        chk("status in release wait", 5'b00100);
        cyc(30);
        chk("status after release", 5'b00101);
        pulse(2);
        rd({LEGACY_SIGNATURE_READ_CMD, 56'h0}, 40, 1'b0, 32'h0000ffff,
           {1'b1, 16'h0, SIGNATURE_CODE, SIGNATURE_CODE});
        cyc(REL2_CYC - 20);
        chk("status in signature wait", 5'b00100);
        cyc(30);
        chk("status after signature", 5'b00101);
        pulse(2);
        chk("status before pin reset", 5'b00110);
        @(posedge ref_clk) rst <= 1'b1;
        cyc(2);
        rst <= 1'b0;
        cyc(3);
        chk("status after pin reset", 5'b00101);
        note("soft reset pulses", 64'd2);
        seen(64'(resetPulses));
        cyc(4);
        wrap_up();
    end

    // watchdog well beyond the expected run time
    initial begin
        #3ms;
        errTotal++;
        wrap_up();
    end
endmodule // tb_top

`default_nettype wire
